// ---- design/tpw_pkg.sv ----
// Shared constants for the PWM-mode timer engine: register map, field
// positions, reset values and count-source encodings.
// Assumes a 32-bit APB slave port with byte addresses on a 12-bit bus.
package tpw_pkg;

  localparam int AW = 12;
  localparam int CW = 16;

  // Register byte offsets
  localparam logic [AW-1:0] OFF_MODE    = 12'h100;
  localparam logic [AW-1:0] OFF_CTRL1   = 12'h104;
  localparam logic [AW-1:0] OFF_IOCTL   = 12'h108;
  localparam logic [AW-1:0] OFF_COUNTER = 12'h10C;
  localparam logic [AW-1:0] OFF_PERIOD  = 12'h110;
  localparam logic [AW-1:0] OFF_CMP_B   = 12'h114;
  localparam logic [AW-1:0] OFF_CMP_C   = 12'h118;
  localparam logic [AW-1:0] OFF_CMP_D   = 12'h11C;
  localparam logic [AW-1:0] OFF_STATUS  = 12'h120;
  localparam logic [AW-1:0] OFF_POLTRIG = 12'h130;

  // timer_mode_register fields
  localparam int MODE_START  = 0;
  localparam int MODE_PWM    = 1;
  localparam int MODE_BFC    = 2;
  localparam int MODE_BFD    = 3;
  localparam int MODE_PIN_LO = 4;   // Pin enables a..d at b4..b7

  // timer_control_one fields
  localparam int CTL_INIT_B = 1;
  localparam int CTL_INIT_C = 2;
  localparam int CTL_INIT_D = 3;
  localparam int CTL_SRC_LO = 4;
  localparam int CTL_SRC_HI = 6;
  localparam int CTL_CLEAR  = 7;

  // io_control_one fields
  localparam int IO_C_FUNC = 3;
  localparam int IO_D_FUNC = 7;

  // polarity_trigger_control fields
  localparam int PT_POL_LO  = 0;
  localparam int PT_POL_HI  = 2;
  localparam int PT_RSV_LO  = 3;
  localparam int PT_RSV_HI  = 4;
  localparam int PT_STOP    = 5;
  localparam int PT_EDGE_LO = 6;
  localparam int PT_EDGE_HI = 7;

  // status fields: matches a..d at b0..b3
  localparam int ST_OVF  = 4;
  localparam int ST_TRIG = 5;

  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_CTRL1   = 8'h00;
  localparam logic [7:0] RST_IOCTL   = 8'h88;
  localparam logic [7:0] RST_POLTRIG = 8'h18;
  localparam logic [1:0] RSV_ONES    = 2'h3;
  localparam logic [CW-1:0] CNT_MAX  = 16'hFFFF;
  localparam logic [CW-1:0] RST_CMP  = 16'hFFFF;

  typedef enum logic [2:0] {
    TPW_SRC_F1, TPW_SRC_F2, TPW_SRC_F4, TPW_SRC_F8,
    TPW_SRC_F32, TPW_SRC_EXT, TPW_SRC_FAST, TPW_SRC_DIVOSC
  } tpw_src_t;

  typedef enum logic [1:0] {
    TPW_EDGE_OFF, TPW_EDGE_RISE, TPW_EDGE_FALL, TPW_EDGE_BOTH
  } tpw_edge_t;

  localparam int PRE_W = 5;   // Prescaler width for the /32 tap

endpackage : tpw_pkg

// ---- design/tpw_cnt_if.sv ----
// Shared counter view handed from the timer core to each compare channel.
// Assumes one clock; all members are driven by the core only.
`timescale 1ns/1ns
interface tpw_cnt_if;
  import tpw_pkg::*;
  logic          tick;
  logic [CW-1:0] counter;
  logic [CW-1:0] period;
  logic          pwm_mode;
  logic          init_load;

  modport src  (output tick, output counter, output period, output pwm_mode, output init_load);
  modport chan (input tick, input counter, input period, input pwm_mode, input init_load);
endinterface : tpw_cnt_if

// ---- design/tpw_chan.sv ----
// One compare channel: match detection and the logical active/inactive level.
// Assumes the core steps counter only on tick and loads init_val on init_load.
`timescale 1ns/1ns
module tpw_chan
  import tpw_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  tpw_cnt_if.chan     cnt,
  input  wire logic [CW-1:0] cmp,
  input  wire logic [CW-1:0] extra_cmp,
  input  wire logic   extra_en,
  input  wire logic   init_val,
  output logic        match,
  output logic        level
);

  logic xmatch;

  // Matches count only on a count-source step
  assign match  = cnt.tick && (cnt.counter == cmp);
  assign xmatch = extra_en && cnt.tick && (cnt.counter == extra_cmp);

  // Level moves only on tick edges and init_load writes, so a mid-period compare write never glitches it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= 1'b0;
    end else if (cnt.init_load) begin
      level <= init_val;
    end else if (cnt.pwm_mode) begin
      if (cmp != cnt.period) begin
        if (match) begin
          level <= 1'b1;
        end else if (cnt.tick && cnt.counter == cnt.period) begin
          level <= 1'b0;
        end
      end
    end else if (match || xmatch) begin
      level <= ~level;
    end
  end

endmodule : tpw_chan

// ---- design/tpw_timer.sv ----
// PWM-mode timer engine: APB registers, count source, 16-bit counter and
// four compare channels driving waveform pins a..d.
// Assumes a single 25 MHz clock; pins and oscillator clocks are asynchronous.
//
// Notes on behaviour
// - Polarity bits b0..b2 pick each pin's active level, PWM mode only.
// - Bits b3 and b4 of polarity register read one, writes ignored.
// - Bit b5 chooses continue or halt at the period match.
// - Field b7:b6 selects trigger edges: off, rising, falling, both.
// - In compare mode, C can also drive pin A and D pin B.
// - Up to three waveforms share one period owned by the period register.
// - Count source: five prescaled clocks, two oscillators, external rising edge.
// - Period lasts m+1 steps; inactive n+1, active m-n.
// - Writing one to count_start starts counting.
// - Stop option clear: writing zero halts; counter and pins hold.
// - Stop option set: counter clears and halts at period match, pins take their period-end level.
// - Each compare match and each overflow raise a request.
// - In PWM mode pin A is a port; B, C, D selectable.
// - Counter readable any time and writable directly.
// - Active level and initial level configured per pin.
// - Initial-level bits set pin levels when control one is written.
// - In PWM mode, compare equal to period never changes that pin.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module tpw_timer
  import tpw_pkg::*;
(
  input  wire logic          SYS_CLK,
  input  wire logic          RESET_N,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [31:0]   PWDATA,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          EXT_COUNT_CLK,
  input  wire logic          FAST_OSC_CLK,
  input  wire logic          DIV_OSC_CLK,
  input  wire logic          EXT_TRIGGER,
  output logic [3:0]         WAVE_O,
  output logic [3:0]         WAVE_OE,
  output logic [4:0]         TIMER_REQ
);

  tpw_cnt_if cif ();

  logic [7:0]    mode, ctrl1, ioctl, poltrig;
  logic [5:0]    status;
  logic [CW-1:0] counter, period, cmp_b, cmp_c, cmp_d;
  logic [PRE_W-1:0] pre;
  logic [3:0]    s1, s2, s3;
  logic          wr, rd_setup, src_tick, tick, period_hit, clear_on_period;
  logic          stop_at_period, overflow, route_cd, trig_hit;
  logic [3:0]    match, level;
  logic [2:0]    pol;
  logic [31:0]   next_rdata;
  logic          mapped;
  tpw_src_t      src;
  tpw_edge_t     edge_sel;

  ////////////////////////////////////////////////////////////////////////
  // APB decode: zero wait states, error on unmapped addresses
  assign wr       = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE;
  assign PREADY   = 1'b1;
  always_comb begin
    unique case (PADDR)
      OFF_MODE, OFF_CTRL1, OFF_IOCTL, OFF_COUNTER, OFF_PERIOD, OFF_CMP_B,
      OFF_CMP_C, OFF_CMP_D, OFF_STATUS, OFF_POLTRIG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Read data captured in setup so the access phase sees a flop output
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (PADDR)
      OFF_MODE:    next_rdata[7:0]    = mode;
      OFF_CTRL1:   next_rdata[7:0]    = ctrl1;
      OFF_IOCTL:   next_rdata[7:0]    = ioctl;
      OFF_COUNTER: next_rdata[CW-1:0] = counter;
      OFF_PERIOD:  next_rdata[CW-1:0] = period;
      OFF_CMP_B:   next_rdata[CW-1:0] = cmp_b;
      OFF_CMP_C:   next_rdata[CW-1:0] = cmp_c;
      OFF_CMP_D:   next_rdata[CW-1:0] = cmp_d;
      OFF_STATUS:  next_rdata[5:0]    = status;
      OFF_POLTRIG: next_rdata[7:0]    = poltrig;
      default:     next_rdata         = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) PRDATA <= 32'h0000_0000;
    else if (rd_setup) PRDATA <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ctrl1   <= RST_CTRL1;
      ioctl   <= RST_IOCTL;
      poltrig <= RST_POLTRIG;
      period  <= RST_CMP;
      cmp_b   <= RST_CMP;
      cmp_c   <= RST_CMP;
      cmp_d   <= RST_CMP;
    end else if (wr) begin
      if (PADDR == OFF_CTRL1)  ctrl1 <= PWDATA[7:0];
      if (PADDR == OFF_IOCTL)  ioctl <= PWDATA[7:0];
      if (PADDR == OFF_POLTRIG) begin
        poltrig <= {PWDATA[PT_EDGE_HI:PT_STOP], RSV_ONES, PWDATA[PT_POL_HI:PT_POL_LO]};
      end
      if (PADDR == OFF_PERIOD) period <= PWDATA[CW-1:0];
      if (PADDR == OFF_CMP_B)  cmp_b  <= PWDATA[CW-1:0];
      if (PADDR == OFF_CMP_C)  cmp_c  <= PWDATA[CW-1:0];
      if (PADDR == OFF_CMP_D)  cmp_d  <= PWDATA[CW-1:0];
    end
  end

  assign pol            = poltrig[PT_POL_HI:PT_POL_LO];
  assign stop_at_period = poltrig[PT_STOP];
  assign edge_sel       = tpw_edge_t'(poltrig[PT_EDGE_HI:PT_EDGE_LO]);
  assign src            = tpw_src_t'(ctrl1[CTL_SRC_HI:CTL_SRC_LO]);
  // Routing C to A and D to B needs both selects and both buffers clear
  assign route_cd = !mode[MODE_PWM] && !ioctl[IO_C_FUNC] && !ioctl[IO_D_FUNC]
                  && !mode[MODE_BFC] && !mode[MODE_BFD];

  // Mode register; hardware clears count_start on a halting period match
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      mode <= RST_MODE;
    end else if (wr && PADDR == OFF_MODE) begin
      mode <= PWDATA[7:0];
    end else if (period_hit && stop_at_period) begin
      mode[MODE_START] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: stage s1 feeds only s2
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
    end else begin
      s1 <= {EXT_TRIGGER, DIV_OSC_CLK, FAST_OSC_CLK, EXT_COUNT_CLK};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Free prescaler; oscillators are edge-sampled, so above 12.5 MHz they alias
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) pre <= '0;
    else pre <= pre + 1'b1;
  end

  always_comb begin
    unique case (src)
      TPW_SRC_F1:     src_tick = 1'b1;
      TPW_SRC_F2:     src_tick = pre[0];
      TPW_SRC_F4:     src_tick = &pre[1:0];
      TPW_SRC_F8:     src_tick = &pre[2:0];
      TPW_SRC_F32:    src_tick = &pre;
      TPW_SRC_EXT:    src_tick = s2[0] && !s3[0];
      TPW_SRC_FAST:   src_tick = s2[1] && !s3[1];
      TPW_SRC_DIVOSC: src_tick = s2[2] && !s3[2];
    endcase
  end

  // Trigger edge detect; recorded only in the status trigger flag
  always_comb begin
    unique case (edge_sel)
      TPW_EDGE_OFF:  trig_hit = 1'b0;
      TPW_EDGE_RISE: trig_hit = s2[3] && !s3[3];
      TPW_EDGE_FALL: trig_hit = !s2[3] && s3[3];
      TPW_EDGE_BOTH: trig_hit = s2[3] ^ s3[3];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter: steps only while started, period clears in PWM mode
  assign tick            = mode[MODE_START] && src_tick;
  assign period_hit      = tick && (counter == period);
  assign clear_on_period = mode[MODE_PWM] || ctrl1[CTL_CLEAR];
  assign overflow        = tick && (counter == CNT_MAX) && !(period_hit && clear_on_period);

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      counter <= '0;
    end else if (wr && PADDR == OFF_COUNTER) begin
      counter <= PWDATA[CW-1:0];
    end else if (period_hit && (clear_on_period || stop_at_period)) begin
      counter <= '0;
    end else if (tick) begin
      counter <= counter + 1'b1;
    end
  end

  assign cif.tick      = tick;
  assign cif.counter   = counter;
  assign cif.period    = period;
  assign cif.pwm_mode  = mode[MODE_PWM];
  assign cif.init_load = wr && PADDR == OFF_CTRL1;

  ////////////////////////////////////////////////////////////////////////
  // Compare channels a..d; a is the period channel in PWM mode
  tpw_chan u_a (.clk(SYS_CLK), .rst_n(RESET_N), .cnt(cif), .cmp(period),
    .extra_cmp(cmp_c), .extra_en(route_cd), .init_val(1'b0),
    .match(match[0]), .level(level[0]));
  tpw_chan u_b (.clk(SYS_CLK), .rst_n(RESET_N), .cnt(cif), .cmp(cmp_b),
    .extra_cmp(cmp_d), .extra_en(route_cd), .init_val(PWDATA[CTL_INIT_B]),
    .match(match[1]), .level(level[1]));
  tpw_chan u_c (.clk(SYS_CLK), .rst_n(RESET_N), .cnt(cif), .cmp(cmp_c),
    .extra_cmp(cmp_c), .extra_en(1'b0), .init_val(PWDATA[CTL_INIT_C]),
    .match(match[2]), .level(level[2]));
  tpw_chan u_d (.clk(SYS_CLK), .rst_n(RESET_N), .cnt(cif), .cmp(cmp_d),
    .extra_cmp(cmp_d), .extra_en(1'b0), .init_val(PWDATA[CTL_INIT_D]),
    .match(match[3]), .level(level[3]));

  // Pin levels: polarity maps logical level in PWM mode only
  always_comb begin
    WAVE_O[0] = level[0];
    for (int i = 1; i < 4; i++) begin
      WAVE_O[i] = mode[MODE_PWM] ? (level[i] ~^ pol[i-1]) : level[i];
    end
  end
  // Pin A is a port in PWM mode; routed C, D pins fall back to port
  assign WAVE_OE[0] = mode[MODE_PIN_LO] && !mode[MODE_PWM];
  assign WAVE_OE[1] = mode[MODE_PIN_LO+1];
  assign WAVE_OE[2] = mode[MODE_PIN_LO+2] && !route_cd;
  assign WAVE_OE[3] = mode[MODE_PIN_LO+3] && !route_cd;

  ////////////////////////////////////////////////////////////////////////
  // Request pulses and sticky status; a new event beats a write-one clear
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      TIMER_REQ <= 5'h00;
      status    <= 6'h00;
    end else begin
      TIMER_REQ <= {overflow, match};
      status    <= (status & ~((wr && PADDR == OFF_STATUS) ? PWDATA[5:0] : 6'h00))
                 | {trig_hit, overflow, match};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  logic sw_cnt_wr, sw_mode_wr;
  assign sw_cnt_wr  = wr && PADDR == OFF_COUNTER;
  assign sw_mode_wr = wr && PADDR == OFF_MODE;

  sequence s_pwm_wrap;
    period_hit && mode[MODE_PWM] && !sw_cnt_wr && !cif.init_load;
  endsequence
  sequence s_b_match;
    tick && counter == cmp_b && cmp_b != period && mode[MODE_PWM] && !cif.init_load;
  endsequence

  a_period_wrap: assert property (s_pwm_wrap |=> counter == '0)
    else $error("counter not cleared at period match");
  a_wrap_inactive: assert property (s_pwm_wrap ##0 (cmp_b != period) |=> !level[1])
    else $error("channel b not inactive at period start");
  a_match_active: assert property (s_b_match |=> level[1])
    else $error("channel b not active after match");
  a_equal_hold: assert property (s_pwm_wrap ##0 (cmp_d == period) |=> $stable(level[3]))
    else $error("channel d moved on period-equal match");
  a_stop_hold: assert property (!mode[MODE_START] && !sw_cnt_wr |=> $stable(counter))
    else $error("counter moved while stopped");
  a_halt_period: assert property (period_hit && stop_at_period && !sw_mode_wr
    |=> !mode[MODE_START] ##1 !mode[MODE_START] || sw_mode_wr)
    else $error("counter did not halt at period match");
  a_start_write: assert property (sw_mode_wr && PWDATA[MODE_START] |=> mode[MODE_START])
    else $error("start write ignored");
  a_pin_a_port: assert property (mode[MODE_PWM] |-> !WAVE_OE[0])
    else $error("pin a driven in PWM mode");
  a_reserved_ones: assert property (rd_setup && PADDR == OFF_POLTRIG
    |=> PRDATA[PT_RSV_HI:PT_RSV_LO] == RSV_ONES)
    else $error("reserved bits not read as one");
  a_overflow_req: assert property (overflow |=> TIMER_REQ[ST_OVF] ##1 status[ST_OVF])
    else $error("overflow request missing");
  a_polarity_b: assert property (mode[MODE_PWM] |-> WAVE_O[1] == (level[1] ~^ pol[0]))
    else $error("pin b polarity wrong");

endmodule : tpw_timer

// ---- tb/tpw_load.sv ----
// Waveform load model: tallies high and low run lengths and edges of one pin.
// Assumes the pin is sampled on the system clock; meas low restarts the run tally at one and clears the edge tally.
`timescale 1ns/1ns
module tpw_load (
  input  wire logic        clk,
  input  wire logic        lvl,
  input  wire logic        meas,
  output logic [15:0]      hi_w,
  output logic [15:0]      lo_w,
  output logic [15:0]      edges
);
  logic        last;
  logic [15:0] run;
  ////////////////////////////////////////////////////////////////////////////////
  // Run tally; a partial first run is reported too, until a complete run overwrites it
  always_ff @(posedge clk) begin
    if (!meas) begin
      run   <= 16'h0001;
      edges <= 16'h0000;
      last  <= lvl;
    end else if (lvl !== last) begin
      if (last) begin
        hi_w <= run;
      end else begin
        lo_w <= run;
      end
      run   <= 16'h0001;
      edges <= edges + 16'h0001;
      last  <= lvl;
    end else begin
      run <= run + 16'h0001;
    end
  end
endmodule : tpw_load

// ---- tb/tpw_timer_test.sv ----
// Self-checking bench for the PWM timer: APB master, pin loads, random duties.
// Assumes zero-wait APB answers are still waited for under a bounded loop.
`timescale 1ns/1ns
module tpw_timer_test;
  import tpw_pkg::*;
  logic          sys_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic [AW-1:0] paddr   = 12'h000;
  logic          psel    = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite  = 1'b0;
  logic [31:0]   pwdata  = 32'h0;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [2:0]    osc     = 3'h0;
  logic          trig    = 1'b0;
  logic          meas    = 1'b0;
  logic [3:0]    wave_o;
  logic [3:0]    wave_oe;
  logic [4:0]    req;
  logic [4:0]    req_or  = 5'h00;
  logic [15:0]   hi_w [4];
  logic [15:0]   lo_w [4];
  logic [15:0]   edges [4];
  logic [31:0]   rd;
  logic [31:0]   hold;
  logic [3:0]    wv;
  logic          err;
  int            fails = 0;
  int            tests_run = 0;
  int            m;
  int            nb;
  int            nc;
  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;
  tpw_timer tpw_timer_i (.SYS_CLK(sys_clk), .RESET_N(reset_n), .PADDR(paddr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_COUNT_CLK(osc[0]), .FAST_OSC_CLK(osc[1]), .DIV_OSC_CLK(osc[2]),
    .EXT_TRIGGER(trig), .WAVE_O(wave_o), .WAVE_OE(wave_oe), .TIMER_REQ(req));
  // One load per pin, measured only while the timer drives it
  for (genvar g = 0; g < 4; g++) begin : g_load
    tpw_load tpw_load_i (.clk(sys_clk), .lvl(wave_o[g]), .meas(meas & wave_oe[g]),
      .hi_w(hi_w[g]), .lo_w(lo_w[g]), .edges(edges[g]));
  end
  // Sticky record of every request pulse; skipped in reset so no unknown sticks
  always @(posedge sys_clk) begin
    if (reset_n) begin
      req_or <= req_or | req;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask : check
  task automatic test_done();
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  // Entered just after a rising edge; request held until pready is seen
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end else begin
      @(posedge sys_clk);
    end
  endtask : apb
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask : rdchk
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : ticks
  // Expected pin active run length from period m and compare n
  function automatic logic [31:0] act_w(input int pm, input int pn);
    return pm - pn;
  endfunction : act_w
  // Divide ratio of the prescaled source codes f1, f2, f4, f8, f32
  function automatic int src_div(input int s);
    return (s == 4) ? 32 : (1 << s);
  endfunction : src_div
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(12898));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    ticks(5);
    rdchk("poltrig reset", OFF_POLTRIG, {24'h0, RST_POLTRIG});
    rdchk("ioctl reset", OFF_IOCTL, {24'h0, RST_IOCTL});
    wr(12'h0FC, 32'h000000FF);
    check("unmapped err", {31'h0, err}, 32'h1);
    rdchk("unmapped data", 12'h0FC, 32'h0);
    // Every trigger edge code against both pin edges
    for (int e = 0; e < 4; e++) begin
      wr(OFF_POLTRIG, e << 6);
      rdchk("poltrig rw", OFF_POLTRIG, (e << 6) | 32'h18);
      wr(OFF_STATUS, 32'h3F);
      trig <= 1'b1;
      ticks(6);
      rdchk("rise trig", OFF_STATUS, (e & 1) ? 32'h20 : 32'h0);
      wr(OFF_STATUS, 32'h3F);
      trig <= 1'b0;
      ticks(6);
      rdchk("fall trig", OFF_STATUS, (e & 2) ? 32'h20 : 32'h0);
    end
    m = $urandom;
    wr(OFF_COUNTER, m & 32'hFFFF);
    rdchk("counter rw", OFF_COUNTER, m & 32'hFFFF);
    // Slow pin sources: five rising edges each
    for (int s = 0; s < 3; s++) begin
      wr(OFF_CTRL1, (s + 5) << 4);
      wr(OFF_COUNTER, 32'h0);
      wr(OFF_MODE, 32'h01);
      repeat (5) begin
        osc[s] <= 1'b1;
        ticks(4);
        osc[s] <= 1'b0;
        ticks(4);
      end
      wr(OFF_MODE, 32'h00);
      rdchk("source count", OFF_COUNTER, 32'h5);
    end
    // Prescaled sources: start and stop writes bound a 128-edge run window
    for (int s = 0; s < 5; s++) begin
      wr(OFF_CTRL1, s << 4);
      wr(OFF_COUNTER, 32'h0);
      wr(OFF_MODE, 32'h01);
      ticks(125);
      wr(OFF_MODE, 32'h00);
      rdchk("prescaled count", OFF_COUNTER, 32'h80 / src_div(s));
    end
    // PWM runs: first a one-step corner, then random duties
    for (int it = 0; it < 3; it++) begin
      m  = it ? $urandom_range(40, 2) : 1;
      nb = it ? $urandom_range(m - 1, 0) : 0;
      nc = $urandom_range(m - 1, 0);
      wr(OFF_POLTRIG, 32'h05);
      wr(OFF_PERIOD, m);
      wr(OFF_CMP_B, nb);
      wr(OFF_CMP_C, nc);
      wr(OFF_CMP_D, m);
      wr(OFF_CTRL1, 32'h0);
      wr(OFF_COUNTER, 32'h0);
      wr(OFF_STATUS, 32'h3F);
      wr(OFF_MODE, 32'hF3);
      check("pin enables", wave_oe, 4'hE);
      meas <= 1'b1;
      ticks(4 * (m + 1) + 4);
      check("b active", hi_w[1], act_w(m, nb));
      check("b inactive", lo_w[1], nb + 1);
      check("c active", lo_w[2], act_w(m, nc));
      check("c inactive", hi_w[2], nc + 1);
      check("d steady", edges[3], 32'h0);
      rdchk("match flags", OFF_STATUS, 32'h0F);
      meas <= 1'b0;
      wr(OFF_MODE, 32'hF2);
    end
    wr(OFF_MODE, 32'hF3);
    ticks(m + 3);
    wr(OFF_MODE, 32'hF2);
    apb(1'b0, OFF_COUNTER, 32'h0);
    hold = rd;
    wv   = wave_o;
    ticks(2 * m + 5);
    rdchk("count hold", OFF_COUNTER, hold);
    check("pins hold", wave_o, wv);
    wr(OFF_POLTRIG, 32'h25);
    wr(OFF_COUNTER, 32'h0);
    wr(OFF_MODE, 32'hF3);
    ticks(2 * m + 10);
    rdchk("halt start", OFF_MODE, 32'hF2);
    rdchk("halt count", OFF_COUNTER, 32'h0);
    check("halt pins", wave_o[3:1], 3'h2);
    wr(OFF_POLTRIG, 32'h05);
    wr(OFF_CTRL1, 32'h0A);
    check("init levels", wave_o[3:1], 3'h7);
    wr(OFF_CTRL1, 32'h04);
    check("init levels", wave_o[3:1], 3'h0);
    // Compare C and D as second sources of pins A and B in compare mode
    wr(OFF_IOCTL, 32'h0);
    wr(OFF_PERIOD, 32'h7);
    wr(OFF_CMP_C, 32'h3);
    wr(OFF_CTRL1, 32'h80);
    wr(OFF_COUNTER, 32'h0);
    wr(OFF_CMP_B, 32'h1);
    wr(OFF_CMP_D, 32'h5);
    wr(OFF_MODE, 32'h31);
    meas <= 1'b1;
    ticks(64);
    check("a two sources", {31'h0, edges[0] >= 16'h000F}, 32'h1);
    check("b two sources", {31'h0, edges[1] >= 16'h000F}, 32'h1);
    meas <= 1'b0;
    wr(OFF_MODE, 32'h00);
    // Counter wrap past the top raises the overflow flag
    wr(OFF_COUNTER, 32'hFFFE);
    wr(OFF_STATUS, 32'h3F);
    wr(OFF_MODE, 32'h01);
    ticks(2);
    wr(OFF_MODE, 32'h00);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("overflow flag", rd & (32'h1 << ST_OVF), 32'h1 << ST_OVF);
    check("requests seen", req_or, 5'h1F);
    test_done();
  end
endmodule : tpw_timer_test
